// ===== cfd_defines.svh
`ifndef CFD_DEFINES_SVH
`define CFD_DEFINES_SVH

// register addresses
`define CFD_A_MSG_CTRL_LO 4'h0
`define CFD_A_MSG_CTRL_HI 4'h1
`define CFD_A_MSG_STAT 4'h2
`define CFD_A_MSG_UA_LO 4'h3
`define CFD_A_MSG_UA_HI 4'h4
`define CFD_A_EV_CTRL_HI 4'h5
`define CFD_A_EV_CTRL_LO 4'h6
`define CFD_A_EV_STAT 4'h7
`define CFD_A_EV_UA_LO 4'h8
`define CFD_A_EV_UA_HI 4'h9
`define CFD_A_MODE 4'hA

// field positions
`define CFD_B_RESET 10
`define CFD_B_SEND 9
`define CFD_B_ADV 8
`define CFD_B_DIR 7
`define CFD_B_ABORT 7
`define CFD_B_LARB 6
`define CFD_B_BERR 5
`define CFD_B_TSEN 5
`define CFD_B_OVF 3
`define CFD_B_EF 2
`define CFD_B_HALF 1
`define CFD_B_NF 0
`define CFD_F_DEPTH 12:8
`define CFD_F_INDEX 12:8
`define CFD_F_IE 3:0
`define CFD_F_MODE 2:0
`define CFD_F_UA_LO 15:0
`define CFD_F_UA_HI 31:16

// reset values and codes
`define CFD_MODE_CONFIG 3'h4
`define CFD_MODE_RESET 3'h4
`define CFD_DEPTH_RESET 5'h00
`define CFD_IE_RESET 4'h0
`define CFD_WORD_ZERO 16'h0000

// message memory layout
`define CFD_MSG_BASE 32'h00000400
`define CFD_MSG_ELEM 32'h00000048
`define CFD_EV_BASE 32'h00000100
`define CFD_EV_ELEM 32'h00000008
`define CFD_EV_ELEM_TS 32'h0000000C

`endif

// ===== cfd_pkg.sv
package cfd_pkg;
  typedef logic [4:0] cfd_ptr_t;
  typedef logic [5:0] cfd_cnt_t;
  typedef logic [15:0] cfd_word_t;
  typedef logic [2:0] cfd_mode_t;
endpackage

// ===== cfd_fifo_status.sv
// How it works
// - direction bit picks transmit or receive meaning
// - transmit: empty/full flag set when empty
// - receive: empty/full flag set when full
// - transmit: half flag when at most half
// - receive: half flag when at least half
// - transmit: lowest flag set while slot free
// - receive: lowest flag set while messages held
// - message index is zero-based slot number
// - arbitration/error bits change on completion or reset
// - abort bit cleared by read, reset, request
// - event depth is field plus one
// - depth and timestamp enable only in config
// - event reset bit self-clears after reset
// - tail advance moves tail by one
// - timestamp stored only when enabled
// - four event interrupt enables, bits three-zero
// - overflow flag sticky on push when full
// - event full/half/nonempty mirror occupancy
// - user address: head for transmit, tail receive
//
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`include "cfd_defines.svh"

module cfd_fifo_status (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  input wire logic tx_done_i,
  input wire logic tx_abort_i,
  input wire logic tx_lost_arb_i,
  input wire logic tx_bus_err_i,
  input wire logic rx_store_i,
  output logic send_pending_o,
  output logic abort_req_o,
  input wire logic ev_push_i,
  input wire logic [31:0] ev_timestamp_i,
  output logic ev_store_o,
  output logic [31:0] ev_store_addr_o,
  output logic ev_store_ts_o,
  output logic [31:0] ev_store_time_o,
  output logic ev_irq_o
);

  function automatic cfd_pkg::cfd_cnt_t depth_of(
    input cfd_pkg::cfd_ptr_t f
  );
    return {1'b0, f} + 6'h01;
  endfunction

  function automatic cfd_pkg::cfd_ptr_t ptr_next(
    input cfd_pkg::cfd_ptr_t p,
    input cfd_pkg::cfd_ptr_t f
  );
    return (p == f) ? 5'h00 : p + 5'h01;
  endfunction

  function automatic cfd_pkg::cfd_cnt_t cnt_next(
    input cfd_pkg::cfd_cnt_t c,
    input logic push,
    input logic pop
  );
    cfd_pkg::cfd_cnt_t r;
    r = c;
    if (push && !pop)
    begin
      r = c + 6'h01;
    end
    else if (pop && !push)
    begin
      r = c - 6'h01;
    end
    return r;
  endfunction

  function automatic logic [31:0] user_addr(
    input logic [31:0] base,
    input cfd_pkg::cfd_ptr_t p,
    input logic [31:0] elem
  );
    return base + ({27'h0, p} * elem);
  endfunction

  cfd_pkg::cfd_mode_t operating_mode_field;
  logic direction_select;
  cfd_pkg::cfd_ptr_t depth_field;
  logic send_request;
  logic msg_reset_pend;
  cfd_pkg::cfd_ptr_t msg_head;
  cfd_pkg::cfd_ptr_t msg_tail;
  cfd_pkg::cfd_cnt_t msg_count;
  logic abort_status;
  logic lost_arbitration_status;
  logic send_bus_error_status;
  logic msg_overflow;

  cfd_pkg::cfd_ptr_t ev_depth_field;
  logic event_timestamp_enable;
  logic [3:0] ev_irq_enable;
  logic ev_reset_pend;
  cfd_pkg::cfd_ptr_t ev_head;
  cfd_pkg::cfd_ptr_t ev_tail;
  cfd_pkg::cfd_cnt_t ev_count;
  logic event_overflow_flag;

  logic cfg_mode;
  logic wr_msg_lo;
  logic wr_msg_hi;
  logic wr_msg_stat;
  logic wr_ev_hi;
  logic wr_ev_lo;
  logic wr_ev_stat;
  logic rd_msg_stat;
  logic msg_adv;
  logic msg_full;
  logic msg_empty;
  logic msg_push;
  logic msg_pop;
  logic send_rise;
  logic empty_or_full_flag;
  logic half_level_flag;
  logic space_or_content_flag;
  cfd_pkg::cfd_ptr_t message_index;
  logic [31:0] user_address;
  logic ev_full;
  logic ev_push_ok;
  logic ev_pop;
  logic event_full_flag;
  logic event_half_flag;
  logic event_nonempty_flag;
  logic [31:0] ev_elem;
  logic [31:0] ev_user_address;
  logic [3:0] ev_flags;
  cfd_pkg::cfd_word_t next_rdata;

  // register decode
  assign cfg_mode = operating_mode_field == `CFD_MODE_CONFIG;
  assign wr_msg_lo = reg_wr_i && reg_addr_i == `CFD_A_MSG_CTRL_LO;
  assign wr_msg_hi = reg_wr_i && reg_addr_i == `CFD_A_MSG_CTRL_HI;
  assign wr_msg_stat = reg_wr_i && reg_addr_i == `CFD_A_MSG_STAT;
  assign wr_ev_hi = reg_wr_i && reg_addr_i == `CFD_A_EV_CTRL_HI;
  assign wr_ev_lo = reg_wr_i && reg_addr_i == `CFD_A_EV_CTRL_LO;
  assign wr_ev_stat = reg_wr_i && reg_addr_i == `CFD_A_EV_STAT;
  assign rd_msg_stat = reg_rd_i && reg_addr_i == `CFD_A_MSG_STAT;

  // message queue occupancy
  assign msg_adv = wr_msg_lo && reg_wdata_i[`CFD_B_ADV];
  assign msg_full = msg_count == depth_of(depth_field);
  assign msg_empty = msg_count == 6'h00;
  assign msg_push = direction_select ? (msg_adv && !msg_full)
                                     : (rx_store_i && !msg_full);
  assign msg_pop = direction_select ? (tx_done_i && !msg_empty)
                                    : (msg_adv && !msg_empty);
  assign send_rise = wr_msg_lo && reg_wdata_i[`CFD_B_SEND] &&
                     direction_select && !send_request;

  // status flags by direction
  always_comb
  begin
    if (direction_select)
    begin
      empty_or_full_flag = msg_empty;
      half_level_flag = {msg_count, 1'b0} <=
                        {1'b0, depth_of(depth_field)};
      space_or_content_flag = !msg_full;
      message_index = msg_tail;
      user_address = user_addr(`CFD_MSG_BASE, msg_head,
                               `CFD_MSG_ELEM);
    end
    else
    begin
      empty_or_full_flag = msg_full;
      half_level_flag = {msg_count, 1'b0} >=
                        {1'b0, depth_of(depth_field)};
      space_or_content_flag = !msg_empty;
      message_index = msg_head;
      user_address = user_addr(`CFD_MSG_BASE, msg_tail,
                               `CFD_MSG_ELEM);
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      operating_mode_field <= `CFD_MODE_RESET;
    end
    else if (reg_wr_i && reg_addr_i == `CFD_A_MODE)
    begin
      operating_mode_field <= reg_wdata_i[`CFD_F_MODE];
    end
  end

  // message queue configuration
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      direction_select <= 1'h0;
      depth_field <= `CFD_DEPTH_RESET;
    end
    else
    begin
      if (wr_msg_lo && cfg_mode)
      begin
        direction_select <= reg_wdata_i[`CFD_B_DIR];
      end
      if (wr_msg_hi && cfg_mode)
      begin
        depth_field <= reg_wdata_i[`CFD_F_DEPTH];
      end
    end
  end

  // message queue reset request, cleared once applied
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      msg_reset_pend <= 1'h0;
    end
    else if (wr_msg_lo && reg_wdata_i[`CFD_B_RESET])
    begin
      msg_reset_pend <= 1'h1;
    end
    else if (msg_reset_pend)
    begin
      msg_reset_pend <= 1'h0;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i || msg_reset_pend)
    begin
      msg_head <= 5'h00;
      msg_tail <= 5'h00;
      msg_count <= 6'h00;
    end
    else
    begin
      if (msg_push)
      begin
        msg_head <= ptr_next(msg_head, depth_field);
      end
      if (msg_pop)
      begin
        msg_tail <= ptr_next(msg_tail, depth_field);
      end
      msg_count <= cnt_next(msg_count, msg_push, msg_pop);
    end
  end

  // send request and abort request
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i || msg_reset_pend)
    begin
      send_request <= 1'h0;
      abort_req_o <= 1'h0;
    end
    else
    begin
      abort_req_o <= wr_msg_lo && send_request &&
                     !reg_wdata_i[`CFD_B_SEND];
      if (send_rise)
      begin
        send_request <= 1'h1;
      end
      else if (wr_msg_lo && !reg_wdata_i[`CFD_B_SEND])
      begin
        send_request <= 1'h0;
      end
      else if (msg_pop && msg_count == 6'h01 && !msg_push)
      begin
        send_request <= 1'h0;
      end
    end
  end

  assign send_pending_o = send_request && direction_select && !msg_empty;

  // completion status; a new abort beats a same-cycle clear
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      abort_status <= 1'h0;
    end
    else if (tx_abort_i && direction_select)
    begin
      abort_status <= 1'h1;
    end
    else if (rd_msg_stat || msg_reset_pend || send_rise)
    begin
      abort_status <= 1'h0;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i || msg_reset_pend)
    begin
      lost_arbitration_status <= 1'h0;
      send_bus_error_status <= 1'h0;
    end
    else if ((tx_done_i || tx_abort_i) && direction_select)
    begin
      lost_arbitration_status <= tx_lost_arb_i;
      send_bus_error_status <= tx_bus_err_i;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i || msg_reset_pend)
    begin
      msg_overflow <= 1'h0;
    end
    else if (rx_store_i && !direction_select && msg_full)
    begin
      msg_overflow <= 1'h1;
    end
    else if (wr_msg_stat && !reg_wdata_i[`CFD_B_OVF])
    begin
      msg_overflow <= 1'h0;
    end
  end

  // event queue
  assign ev_full = ev_count == depth_of(ev_depth_field);
  assign ev_push_ok = ev_push_i && !ev_full;
  assign ev_pop = wr_ev_lo && reg_wdata_i[`CFD_B_ADV] &&
                  ev_count != 6'h00;
  assign event_full_flag = ev_full;
  assign event_half_flag = {ev_count, 1'b0} >=
                           {1'b0, depth_of(ev_depth_field)};
  assign event_nonempty_flag = ev_count != 6'h00;
  assign ev_elem = event_timestamp_enable ? `CFD_EV_ELEM_TS
                                          : `CFD_EV_ELEM;
  assign ev_user_address = user_addr(`CFD_EV_BASE, ev_tail, ev_elem);
  assign ev_flags = {event_overflow_flag, event_full_flag,
                     event_half_flag, event_nonempty_flag};

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      ev_depth_field <= `CFD_DEPTH_RESET;
      event_timestamp_enable <= 1'h0;
      ev_irq_enable <= `CFD_IE_RESET;
    end
    else
    begin
      if (wr_ev_hi && cfg_mode)
      begin
        ev_depth_field <= reg_wdata_i[`CFD_F_DEPTH];
      end
      if (wr_ev_lo)
      begin
        ev_irq_enable <= reg_wdata_i[`CFD_F_IE];
        if (cfg_mode)
        begin
          event_timestamp_enable <= reg_wdata_i[`CFD_B_TSEN];
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      ev_reset_pend <= 1'h0;
    end
    else if (wr_ev_lo && reg_wdata_i[`CFD_B_RESET])
    begin
      ev_reset_pend <= 1'h1;
    end
    else if (ev_reset_pend)
    begin
      ev_reset_pend <= 1'h0;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i || ev_reset_pend)
    begin
      ev_head <= 5'h00;
      ev_tail <= 5'h00;
      ev_count <= 6'h00;
    end
    else
    begin
      if (ev_push_ok)
      begin
        ev_head <= ptr_next(ev_head, ev_depth_field);
      end
      if (ev_pop)
      begin
        ev_tail <= ptr_next(ev_tail, ev_depth_field);
      end
      ev_count <= cnt_next(ev_count, ev_push_ok, ev_pop);
    end
  end

  // overflow: a push while full beats a same-cycle clear
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i || ev_reset_pend)
    begin
      event_overflow_flag <= 1'h0;
    end
    else if (ev_push_i && ev_full)
    begin
      event_overflow_flag <= 1'h1;
    end
    else if (wr_ev_stat && !reg_wdata_i[`CFD_B_OVF])
    begin
      event_overflow_flag <= 1'h0;
    end
  end

  // event element write toward message memory
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      ev_store_o <= 1'h0;
      ev_store_addr_o <= 32'h00000000;
      ev_store_ts_o <= 1'h0;
      ev_store_time_o <= 32'h00000000;
    end
    else
    begin
      ev_store_o <= ev_push_ok;
      if (ev_push_ok)
      begin
        ev_store_addr_o <= user_addr(`CFD_EV_BASE, ev_head, ev_elem);
        ev_store_ts_o <= event_timestamp_enable;
        ev_store_time_o <= event_timestamp_enable ? ev_timestamp_i
                                                  : 32'h00000000;
      end
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      ev_irq_o <= 1'h0;
    end
    else
    begin
      ev_irq_o <= |(ev_flags & ev_irq_enable);
    end
  end

  // read mux
  always_comb
  begin
    next_rdata = `CFD_WORD_ZERO;
    unique case (reg_addr_i)
      `CFD_A_MSG_CTRL_LO:
      begin
        next_rdata[`CFD_B_RESET] = msg_reset_pend;
        next_rdata[`CFD_B_SEND] = send_request;
        next_rdata[`CFD_B_DIR] = direction_select;
      end
      `CFD_A_MSG_CTRL_HI:
      begin
        next_rdata[`CFD_F_DEPTH] = depth_field;
      end
      `CFD_A_MSG_STAT:
      begin
        next_rdata[`CFD_F_INDEX] = message_index;
        next_rdata[`CFD_B_ABORT] = abort_status;
        next_rdata[`CFD_B_LARB] = lost_arbitration_status;
        next_rdata[`CFD_B_BERR] = send_bus_error_status;
        next_rdata[`CFD_B_OVF] = msg_overflow && !direction_select;
        next_rdata[`CFD_B_EF] = empty_or_full_flag;
        next_rdata[`CFD_B_HALF] = half_level_flag;
        next_rdata[`CFD_B_NF] = space_or_content_flag;
      end
      `CFD_A_MSG_UA_LO:
      begin
        next_rdata = user_address[`CFD_F_UA_LO];
      end
      `CFD_A_MSG_UA_HI:
      begin
        next_rdata = user_address[`CFD_F_UA_HI];
      end
      `CFD_A_EV_CTRL_HI:
      begin
        next_rdata[`CFD_F_DEPTH] = ev_depth_field;
      end
      `CFD_A_EV_CTRL_LO:
      begin
        next_rdata[`CFD_B_RESET] = ev_reset_pend;
        next_rdata[`CFD_B_TSEN] = event_timestamp_enable;
        next_rdata[`CFD_F_IE] = ev_irq_enable;
      end
      `CFD_A_EV_STAT:
      begin
        next_rdata[`CFD_F_IE] = ev_flags;
      end
      `CFD_A_EV_UA_LO:
      begin
        next_rdata = ev_user_address[`CFD_F_UA_LO];
      end
      `CFD_A_EV_UA_HI:
      begin
        next_rdata = ev_user_address[`CFD_F_UA_HI];
      end
      `CFD_A_MODE:
      begin
        next_rdata[`CFD_F_MODE] = operating_mode_field;
      end
      default:
      begin
        next_rdata = `CFD_WORD_ZERO;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      reg_rdata_o <= `CFD_WORD_ZERO;
    end
    else
    begin
      reg_rdata_o <= reg_rd_i ? next_rdata : `CFD_WORD_ZERO;
    end
  end

endmodule

// ===== cfd_fifo_status_checker.sv
`timescale 1ns/1ps
`include "cfd_defines.svh"
module cfd_fifo_status_checker (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic abort_req_o,
  input wire logic ev_push_i,
  input wire logic [31:0] ev_timestamp_i,
  input wire logic ev_store_o,
  input wire logic [31:0] ev_store_addr_o,
  input wire logic ev_store_ts_o,
  input wire logic [31:0] ev_store_time_o
);
  logic [2:0] mode;
  logic [4:0] dsh;
  logic rd_prev;
  logic [3:0] a_prev;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (srst_i);
  // shadow of mode and event depth, depth only taken in config
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
      mode <= `CFD_MODE_RESET;
    else if (reg_wr_i && reg_addr_i == `CFD_A_MODE)
      mode <= reg_wdata_i[2:0];
  end
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
      dsh <= `CFD_DEPTH_RESET;
    else if (reg_wr_i && reg_addr_i == `CFD_A_EV_CTRL_HI &&
      mode == `CFD_MODE_CONFIG)
      dsh <= reg_wdata_i[12:8];
  end
  always_ff @(posedge sys_clk_i)
  begin
    rd_prev <= reg_rd_i;
    a_prev <= reg_addr_i;
  end
  a_store_needs_push: assert property (ev_store_o |-> $past(ev_push_i))
    else $error("event store without a push");
  a_ts_off_zero: assert property (ev_store_o && !ev_store_ts_o |->
    ev_store_time_o == 32'h00000000) else $error("time stored while off");
  a_ts_on_copy: assert property (ev_store_o && ev_store_ts_o |->
    ev_store_time_o == $past(ev_timestamp_i)) else $error("time not kept");
  a_store_addr_range: assert property (ev_store_o |->
    ev_store_addr_o >= `CFD_EV_BASE &&
    ev_store_addr_o < `CFD_EV_BASE + 32 * `CFD_EV_ELEM_TS)
    else $error("event address out of range");
  a_msg_flag_order: assert property (rd_prev &&
    a_prev == `CFD_A_MSG_STAT && reg_rdata_o[2] |-> reg_rdata_o[1:0] == 2'h3)
    else $error("message flags inconsistent");
  a_ev_flag_order: assert property (rd_prev && a_prev == `CFD_A_EV_STAT |->
    reg_rdata_o[15:4] == 12'h000 && (!reg_rdata_o[2] || reg_rdata_o[1]) &&
    (!reg_rdata_o[1] || reg_rdata_o[0])) else $error("event flags wrong");
  a_ev_ctrl_resv: assert property (rd_prev && a_prev == `CFD_A_EV_CTRL_LO |->
    (reg_rdata_o & 16'hFAD0) == 16'h0000) else $error("reserved bits set");
  a_ev_depth_locked: assert property (rd_prev &&
    a_prev == `CFD_A_EV_CTRL_HI |-> reg_rdata_o == {3'h0, $past(dsh), 8'h00})
    else $error("event depth wrong");
  a_abort_cause: assert property (abort_req_o |-> $past(reg_wr_i) &&
    $past(reg_addr_i) == `CFD_A_MSG_CTRL_LO && !$past(reg_wdata_i[9]))
    else $error("abort without request clear");
endmodule
bind cfd_fifo_status cfd_fifo_status_checker i_chk (
  .sys_clk_i(sys_clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .abort_req_o(abort_req_o),
  .ev_push_i(ev_push_i), .ev_timestamp_i(ev_timestamp_i),
  .ev_store_o(ev_store_o), .ev_store_addr_o(ev_store_addr_o),
  .ev_store_ts_o(ev_store_ts_o), .ev_store_time_o(ev_store_time_o)
);

// ===== cfd_can_peer.sv
`timescale 1ns/1ps
module cfd_can_peer (
  input wire logic clk_i,
  input wire logic pend_i,
  input wire logic abort_i,
  output logic done_o,
  output logic abt_o,
  output logic larb_o,
  output logic berr_o,
  output logic rx_o,
  output logic push_o,
  output logic [31:0] ts_o
);
  int gap = 3;
  int cnt = 0;
  logic [1:0] res = 2'h0;
  initial
  begin
    {done_o, abt_o, larb_o, berr_o, rx_o, push_o} = 6'h00;
    ts_o = 32'h00000000;
  end
  // status levels only mean something beside a completion
  always @(posedge clk_i)
  begin
    done_o <= 1'b0;
    abt_o <= 1'b0;
    {larb_o, berr_o} <= ~{larb_o, berr_o};
    cnt <= (pend_i && !done_o) ? cnt + 1 : 0;
    if (abort_i || (pend_i && !done_o && cnt == gap))
    begin
      abt_o <= abort_i;
      done_o <= !abort_i;
      {larb_o, berr_o} <= res;
    end
  end
  task automatic rx();
    @(posedge clk_i);
    rx_o <= 1'b1;
    @(posedge clk_i);
    rx_o <= 1'b0;
  endtask
  task automatic ev(input logic [31:0] t);
    @(posedge clk_i);
    push_o <= 1'b1;
    ts_o <= t;
    @(posedge clk_i);
    push_o <= 1'b0;
    ts_o <= ~t;
  endtask
endmodule

// ===== tb.sv
`timescale 1ns/1ps
`include "cfd_defines.svh"
`define CHK(a, b) \
  begin \
    checks_done++; \
    if ((a) !== (b)) \
    begin \
      bad_count++; \
      $display("[FAIL] t=%0t got %h exp %h", $time, a, b); \
    end \
  end
module tb;
  logic sys_clk_i, srst_i, reg_wr_i, reg_rd_i;
  logic rd_d = 1'b0;
  logic [3:0] reg_addr_i;
  cfd_pkg::cfd_word_t reg_wdata_i, reg_rdata_o, last;
  logic done, abt, larb, berr, rx, push, pend, abreq, st, sts, irq;
  logic [31:0] ts, sa, stime, t, e;
  logic [64:0] s;
  logic [1:0] r;
  logic [31:0] rq[$];
  logic [64:0] sq[$];
  int bad_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int n;
  cfd_fifo_status i_dut (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .tx_done_i(done),
    .tx_abort_i(abt), .tx_lost_arb_i(larb), .tx_bus_err_i(berr),
    .rx_store_i(rx), .send_pending_o(pend), .abort_req_o(abreq),
    .ev_push_i(push), .ev_timestamp_i(ts), .ev_store_o(st),
    .ev_store_addr_o(sa), .ev_store_ts_o(sts), .ev_store_time_o(stime),
    .ev_irq_o(irq));
  cfd_can_peer i_peer (.clk_i(sys_clk_i), .pend_i(pend), .abort_i(abreq),
    .done_o(done), .abt_o(abt), .larb_o(larb), .berr_o(berr), .rx_o(rx),
    .push_o(push), .ts_o(ts));
  initial
  begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // results checked in the order they were requested
  always @(posedge sys_clk_i)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      bad_count++;
      test_done();
    end
    if (rd_d)
    begin
      last = reg_rdata_o;
      e = rq.pop_front();
      `CHK(reg_rdata_o & e[31:16], e[15:0])
    end
    rd_d <= reg_rd_i;
    if (st)
    begin
      s = sq.pop_front();
      `CHK({sa, sts, stime}, s)
    end
  end
  task automatic wr(input logic [3:0] a, input cfd_pkg::cfd_word_t d);
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input cfd_pkg::cfd_word_t x,
    input cfd_pkg::cfd_word_t m = 16'hFFFF);
    rq.push_back({m, x});
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
  endtask
  task automatic idle();
    @(posedge sys_clk_i);
    for (int k = 0; k < 300 && pend !== 1'b0; k++)
      @(posedge sys_clk_i);
  endtask
  // message status for a four deep queue
  function automatic cfd_pkg::cfd_word_t mst(logic tx, int c, int i,
    logic [4:0] f);
    return {3'h0, 5'(i), f,
      tx ? {c == 0, c <= 2, c < 4} : {c == 4, c >= 2, c >= 1}};
  endfunction
  initial
  begin
    {reg_wr_i, reg_rd_i, srst_i} = 3'h1;
    reg_addr_i = 4'h0;
    reg_wdata_i = 16'h0000;
    void'($urandom(96));
    repeat (6) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    for (int k = 0; k < 16; k++)
      rd(4'(k), k == 3 ? 16'h0400 : k == 8 ? 16'h0100 :
        k == 10 ? 16'h0004 : 16'h0000, 16'hFFFD);
    $display("reset values test done");
    wr(4'h5, 16'h0300);
    wr(4'h6, 16'h0020);
    wr(4'hA, 16'h0000);
    wr(4'h5, 16'h1F00);
    rd(4'h5, 16'h0300);
    for (int c = 1; c <= 5; c++)
    begin
      t = $urandom();
      if (c < 5)
        sq.push_back({`CFD_EV_BASE + 32'((c - 1) * 12), 1'b1, t});
      i_peer.ev(t);
      rd(4'h7, {12'h000, c > 4, c >= 4, c >= 2, 1'b1});
    end
    for (int k = 0; k < 4; k++)
    begin
      wr(4'h6, 16'(1 << k));
      repeat (3) @(posedge sys_clk_i);
      `CHK(irq, 1'b1)
    end
    wr(4'h6, 16'h0100);
    wr(4'h6, 16'h0000);
    rd(4'h7, 16'h000B);
    rd(4'h8, 16'h010C);
    wr(4'h7, 16'h0000);
    wr(4'h6, 16'h000C);
    repeat (3) @(posedge sys_clk_i);
    `CHK(irq, 1'b0)
    rd(4'h7, 16'h0003);
    wr(4'h6, 16'h0400);
    for (int k = 0; k < 8 && (k == 0 || last[10] !== 1'b0); k++)
    begin
      rd(4'h6, 16'h0020, 16'hFBFF);
      repeat (2) @(posedge sys_clk_i);
    end
    rd(4'h7, 16'h0000);
    wr(4'hA, 16'h0004);
    wr(4'h6, 16'h0000);
    sq.push_back({`CFD_EV_BASE, 1'b0, 32'h00000000});
    i_peer.ev($urandom());
    $display("event queue test done");
    wr(4'h1, 16'h0300);
    wr(4'h0, 16'h0080);
    wr(4'hA, 16'h0000);
    for (int c = 0; c < 4; c++)
    begin
      rd(4'h2, mst(1'b1, c, 0, 5'h00));
      rd(4'h3, 16'(`CFD_MSG_BASE + c * `CFD_MSG_ELEM));
      wr(4'h0, 16'h0180);
    end
    rd(4'h2, mst(1'b1, 4, 0, 5'h00));
    r = 2'($urandom());
    i_peer.res = r;
    wr(4'h0, 16'h0280);
    idle();
    repeat (10) @(posedge sys_clk_i);
    rd(4'h2, mst(1'b1, 0, 0, {1'b0, r, 2'h0}));
    rd(4'h0, 16'h0080);
    wr(4'h0, 16'h0180);
    i_peer.gap = 1000;
    i_peer.res = ~r;
    wr(4'h0, 16'h0280);
    wr(4'h0, 16'h0080);
    repeat (4) @(posedge sys_clk_i);
    rd(4'h2, mst(1'b1, 1, 0, {1'b1, ~r, 2'h0}));
    rd(4'h2, mst(1'b1, 1, 0, {1'b0, ~r, 2'h0}));
    i_peer.gap = 3;
    wr(4'h0, 16'h0280);
    idle();
    $display("transmit test done");
    wr(4'hA, 16'h0004);
    wr(4'h0, 16'h0400);
    wr(4'h0, 16'h0000);
    wr(4'hA, 16'h0000);
    for (int c = 1; c <= 5; c++)
    begin
      n = c > 4 ? 4 : c;
      i_peer.rx();
      rd(4'h2, mst(1'b0, n, n % 4, {4'h0, c > 4}));
    end
    rd(4'h3, 16'h0400);
    wr(4'h0, 16'h0100);
    rd(4'h3, 16'h0448);
    rd(4'h2, mst(1'b0, 3, 0, 5'h01));
    repeat (3) @(posedge sys_clk_i);
    $display("receive test done");
    test_done();
  end
endmodule
